/* logic/cbx_regs.vh */
// constants for the branch and bit-clear execute block
`ifndef CBX_REGS_VH
`define CBX_REGS_VH
`define CBX_OP_HI_BRANCH 8'he2
`define CBX_OP_HI_BRNEG 8'he6
`define CBX_OP_BCLR 4'h9
`define CBX_ILO_MAX 8'h5f
`define CBX_ACCESS_SPLIT 8'h60
`define CBX_ACCESS_HI_BANK 4'hf
`define CBX_PC_STEP 21'h000002
`define CBX_PH_Q1 2'd0
`define CBX_PH_Q2 2'd1
`define CBX_PH_Q3 2'd2
`define CBX_PH_Q4 2'd3
`define CBX_PH_STEP 2'd1
`define CBX_OPH_HI 15
`define CBX_OPH_LO 8
`define CBX_OPB_LO 12
`define CBX_BIT_HI 11
`define CBX_BIT_LO 9
`define CBX_ACC_BIT 8
`define CBX_F_HI 7
`define CBX_F_LO 0
`define CBX_REG_DATA 8'h00
`define CBX_REG_ADDR 8'h01
`define CBX_REG_CTRL 8'h02
`define CBX_REG_STAT 8'h03
`define CBX_REG_BSR 8'h04
`define CBX_REG_FSR2L 8'h05
`define CBX_REG_FSR2H 8'h06
`endif

/* logic/cbx_bit_clear.v */
// read-modify-write bit clear helper
`timescale 1ns/1ps
module cbx_bit_clear #(
	parameter W = 8
) (
	input wire [W-1:0] din,
	input wire [2:0] bit_idx,
	output wire [W-1:0] dout
);
	assign dout = din & ~({{(W-1){1'b0}}, 1'b1} << bit_idx);
endmodule

/* logic/cbx_exec.v */
// decode and execute for conditional branches and bit clear
// Functional notes
// - opcode e2 with an 8-bit offset branches when carry is one, else falls through, flags unchanged.
// - opcode e6 with an 8-bit offset branches when negative is one, else falls through, flags unchanged.
// - the target is the incremented pc plus twice the signed offset, so address plus two plus 2n.
// - an untaken branch takes one four-phase cycle; a taken one writes pc in Q4 then idles one cycle.
// - opcode 9 with bit index, access bit and register clears that bit by read-modify-write, flags untouched.
// - access bit zero uses the access bank; one uses the bank select register with the register field.
// - access bit zero with extended set on and register at most 95 uses indexed literal offset addressing.
//
// Added by the designer: the strobed register port and the placing of the registers.
`timescale 1ns/1ps
`include "cbx_regs.vh"
module cbx_exec #(
	parameter PCW = 21
) (
	input wire sys_clk,
	input wire rst,
	input wire instr_valid,
	input wire [15:0] instr_word,
	input wire [PCW-1:0] pc_cur,
	input wire flag_carry,
	input wire flag_negative,
	input wire ext_set_en,
	input wire [5:0] bank_select_register,
	input wire [11:0] fsr2,
	input wire [7:0] mem_rdata,
	output reg busy_r,
	output reg pc_load_r,
	output reg [PCW-1:0] pc_target_r,
	output reg [11:0] mem_addr_r,
	output reg mem_rd_r,
	output reg mem_wr_r,
	output reg [7:0] mem_wdata_r,
	output reg [1:0] phase_r,
	output reg idle_cycle_r
);
	localparam ST_IDLE = 4'b0001;
	localparam ST_BR = 4'b0010;
	localparam ST_BC = 4'b0100;
	localparam ST_NOP = 4'b1000;

	reg [3:0] st_r;
	reg [3:0] st_nxt;
	reg [15:0] ir_r;
	reg take_r;
	reg [7:0] rd_data_r;
	reg [11:0] addr_c;
	wire [7:0] clr_data;
	wire [7:0] ir_f;
	wire [2:0] bit_sel;
	wire bank_sel;
	wire [7:0] op_hi;
	wire [3:0] op_top;
	wire is_bc;
	wire is_bn;
	wire is_bclr;
	wire is_branch;
	wire cond_met;
	wire ph_q1;
	wire ph_q2;
	wire ph_q3;
	wire ph_q4;
	wire accept;
	wire [PCW-1:0] offs2;

	// fields of the fetched word and of the held one
	assign op_hi = instr_word[`CBX_OPH_HI:`CBX_OPH_LO];
	assign op_top = instr_word[`CBX_OPH_HI:`CBX_OPB_LO];
	assign ir_f = ir_r[`CBX_F_HI:`CBX_F_LO];
	assign bit_sel = ir_r[`CBX_BIT_HI:`CBX_BIT_LO];
	assign bank_sel = ir_r[`CBX_ACC_BIT];

	assign is_bc = op_hi == `CBX_OP_HI_BRANCH;
	assign is_bn = op_hi == `CBX_OP_HI_BRNEG;
	assign is_bclr = op_top == `CBX_OP_BCLR;
	assign is_branch = is_bc || is_bn;
	assign cond_met = (is_bc && flag_carry) || (is_bn && flag_negative);

	assign ph_q1 = phase_r == `CBX_PH_Q1;
	assign ph_q2 = phase_r == `CBX_PH_Q2;
	assign ph_q3 = phase_r == `CBX_PH_Q3;
	assign ph_q4 = phase_r == `CBX_PH_Q4;

	// a new word is only looked at in q4 while nothing runs
	assign accept = st_r == ST_IDLE && instr_valid && ph_q4;

	// offset doubled and sign extended to the pc width
	assign offs2 = {{(PCW-9){ir_f[`CBX_F_HI]}}, ir_f, 1'b0};

	cbx_bit_clear #(
		.W(8)
	) u_clr (
		.din(rd_data_r),
		.bit_idx(bit_sel),
		.dout(clr_data)
	);

	always @* begin
		addr_c = {4'h0, ir_f};
		if (bank_sel)
			addr_c = {bank_select_register[3:0], ir_f};
		else if (ext_set_en && ir_f <= `CBX_ILO_MAX)
			addr_c = fsr2 + {4'h0, ir_f};
		else if (ir_f >= `CBX_ACCESS_SPLIT)
			addr_c = {`CBX_ACCESS_HI_BANK, ir_f};
	end

	always @* begin
		st_nxt = st_r;
		case (st_r)
			ST_IDLE: begin
				if (accept && is_branch)
					st_nxt = ST_BR;
				else if (accept && is_bclr)
					st_nxt = ST_BC;
			end
			ST_BR: begin
				if (ph_q4)
					st_nxt = take_r ? ST_NOP : ST_IDLE;
			end
			ST_BC: begin
				if (ph_q4)
					st_nxt = ST_IDLE;
			end
			ST_NOP: begin
				if (ph_q4)
					st_nxt = ST_IDLE;
			end
			default: st_nxt = ST_IDLE;
		endcase
	end

	// q phase counter runs freely out of reset
	always @(posedge sys_clk) begin
		if (rst)
			phase_r <= `CBX_PH_Q1;
		else
			phase_r <= phase_r + `CBX_PH_STEP;
	end

	always @(posedge sys_clk) begin
		if (rst)
			st_r <= ST_IDLE;
		else
			st_r <= st_nxt;
	end

	// word and branch decision are frozen at acceptance
	always @(posedge sys_clk) begin
		if (rst) begin
			ir_r <= 16'h0000;
			take_r <= 1'b0;
		end else if (accept) begin
			ir_r <= instr_word;
			take_r <= cond_met;
		end
	end

	always @(posedge sys_clk) begin
		if (rst)
			pc_target_r <= {PCW{1'b0}};
		else if (st_r == ST_BR && ph_q2)
			pc_target_r <= pc_cur + `CBX_PC_STEP + offs2;
	end

	// load pulse stands in q4 of a taken branch
	always @(posedge sys_clk) begin
		if (rst)
			pc_load_r <= 1'b0;
		else
			pc_load_r <= st_r == ST_BR && ph_q3 && take_r;
	end

	always @(posedge sys_clk) begin
		if (rst) begin
			busy_r <= 1'b0;
			idle_cycle_r <= 1'b0;
		end else begin
			busy_r <= st_nxt != ST_IDLE;
			idle_cycle_r <= st_nxt == ST_NOP;
		end
	end

	// read of the addressed register
	always @(posedge sys_clk) begin
		if (rst) begin
			mem_addr_r <= 12'h000;
			mem_rd_r <= 1'b0;
		end else begin
			mem_rd_r <= st_r == ST_BC && ph_q1;
			if (st_r == ST_BC && ph_q1)
				mem_addr_r <= addr_c;
		end
	end

	always @(posedge sys_clk) begin
		if (rst)
			rd_data_r <= 8'h00;
		else if (st_r == ST_BC && ph_q2)
			rd_data_r <= mem_rdata;
	end

	// write back with the selected bit cleared
	always @(posedge sys_clk) begin
		if (rst) begin
			mem_wdata_r <= 8'h00;
			mem_wr_r <= 1'b0;
		end else begin
			mem_wr_r <= st_r == ST_BC && ph_q3;
			if (st_r == ST_BC && ph_q3)
				mem_wdata_r <= clr_data;
		end
	end
endmodule

/* bench/cbx_exec_asserts.sv */
// checker for cbx_exec
`timescale 1ns/1ps
module cbx_exec_asserts(input wire sys_clk,rst,busy_r,pc_load_r,mem_rd_r,mem_wr_r,idle_cycle_r,
input wire [1:0] phase_r,input wire [11:0] mem_addr_r,input wire [7:0] mem_wdata_r,mem_rdata);
default clocking @(posedge sys_clk); endclocking
default disable iff (rst);
sequence s_idle; idle_cycle_r[*4] ##1 !idle_cycle_r; endsequence
a_phase_run: assert property (!$past(rst) |-> phase_r==$past(phase_r)+2'h1) else $error("phase");
a_taken_idle: assert property ($rose(pc_load_r) |=> s_idle) else $error("idle");
a_load_pulse: assert property (pc_load_r |=> !pc_load_r) else $error("load");
a_rmw_order: assert property (mem_wr_r |-> $past(mem_rd_r,2) && $stable(mem_addr_r)) else $error("rmw");
a_bit_clear: assert property (mem_wr_r |-> !(mem_wdata_r&~mem_rdata) && $countones(mem_wdata_r^mem_rdata)<2)
	else $error("clr");
a_busy_out: assert property (pc_load_r||mem_wr_r||mem_rd_r |-> busy_r) else $error("busy");
a_idle_quiet: assert property (idle_cycle_r |-> busy_r && !mem_rd_r && !pc_load_r) else $error("quiet");
a_one_op: assert property (!(pc_load_r && mem_wr_r)) else $error("both");
endmodule
bind cbx_exec cbx_exec_asserts u_chk(.*);

/* bench/cbx_mem_model.sv */
// data memory model
`timescale 1ns/1ps
module cbx_mem_model(input wire sys_clk,mem_wr_r,input wire [11:0] mem_addr_r,input wire [7:0] mem_wdata_r,
output wire [7:0] mem_rdata);
logic [7:0] m [4096];
initial foreach (m[i]) m[i]=8'hc7;
assign mem_rdata=m[mem_addr_r];
always @(posedge sys_clk) if (mem_wr_r) m[mem_addr_r]<=mem_wdata_r;
endmodule

/* bench/cbx_exec_tb.sv */
// bench for cbx_exec
`timescale 1ns/1ps
module cbx_exec_tb;
logic sys_clk=0,rst=1,instr_valid=0,flag_carry=0,flag_negative=0,ext_set_en=0;
logic [15:0] instr_word=16'h0000;
logic [20:0] pc_cur=21'h000100,pc_target_r,tg;
logic [5:0] bank_select_register=6'h13;
logic [11:0] fsr2=12'h200,mem_addr_r,wa;
logic [7:0] mem_rdata,mem_wdata_r,wd;
logic [1:0] phase_r;
logic busy_r,pc_load_r,mem_rd_r,mem_wr_r,idle_cycle_r;
int fails=0,total_checks=0,nld,nwr;
cbx_exec uut(.*);
cbx_mem_model mem(.*);
always @(posedge sys_clk) begin
	if (pc_load_r) begin nld++; tg=pc_target_r; end
	if (mem_wr_r) begin nwr++; wa=mem_addr_r; wd=mem_wdata_r; end
end
task ck(input string n,input logic [31:0] e,s);
	total_checks++;
	if (e!==s) begin fails++; $display("[ERR] %s exp %h got %h",n,e,s); end
endtask
task ex(input logic [15:0] w,input logic c,g,x,input logic [31:0] et,ea);
	flag_carry<=c; flag_negative<=g; ext_set_en<=x; instr_word<=w; instr_valid<=1; nld=0; nwr=0;
	repeat(4) @(posedge sys_clk);
	instr_valid<=0;
	repeat(9) @(posedge sys_clk);
	ck("load",et!=0,nld);
	if (et) ck("target",et,tg);
	ck("write",ea!=0,nwr);
	if (ea) begin ck("addr",ea,wa); ck("data",8'h47,wd); end
endtask
task complete_run;
	$display("checks %0d fails %0d",total_checks,fails);
	if (fails==0 && total_checks>0) $display("TEST PASSED");
	else $display("TEST FAILED");
	$finish;
endtask
initial forever #50 sys_clk=~sys_clk;
initial begin
	repeat(6) @(posedge sys_clk);
	rst<=0;
	ex(16'he205,1,0,0,21'h10c,0);
	ex(16'he205,0,1,0,0,0);
	ex(16'he680,0,1,0,21'h002,0);
	ex(16'he67f,1,0,0,0,0);
	ex(16'he67f,0,1,0,21'h200,0);
	ex(16'h9e05,0,0,0,0,12'h005);
	ex(16'h9f05,1,1,1,0,12'h305);
	ex(16'h9e5f,0,0,1,0,12'h25f);
	ex(16'h9e60,0,0,1,0,12'hf60);
	complete_run;
end
initial begin #200000; fails++; complete_run; end
endmodule
